// ==== verilog/msc_pkg.sv ====
/*
 * Shared constants for the monitor select command block: register offsets,
 * command identifiers, field positions, status codes and start-up selections.
 * Assumes a 32-bit APB register bus with byte addresses on word boundaries.
 */
package msc_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_COMMAND = 8'h00;
    localparam logic [7:0] OFF_REPLY = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_PARAM_INDEX = 8'h0C;
    localparam logic [7:0] OFF_PARAM_VALUE = 8'h10;
    localparam logic [7:0] OFF_SELECT = 8'h14;

    // ------------------------------------------------------------------
    // Command word fields
    // ------------------------------------------------------------------
    localparam int CMD_ID_LSB = 0;
    localparam int CMD_ID_W = 8;
    localparam int CMD_DATA_LSB = 16;
    localparam int CMD_DATA_W = 16;

    // ------------------------------------------------------------------
    // Command identifiers
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_PARAM_CHECK = 8'h1A;
    localparam logic [7:0] CMD_COORD_SYSTEM = 8'h1E;
    localparam logic [7:0] CMD_SEL_FIRST = 8'h28;
    localparam logic [7:0] CMD_SEL_SECOND = 8'h29;
    localparam logic [7:0] CMD_SEL_THIRD = 8'h2A;
    localparam logic [7:0] CMD_SEL_CHECK = 8'h2B;

    // ------------------------------------------------------------------
    // Status and field layout of the status and select registers
    // ------------------------------------------------------------------
    localparam logic STATUS_OK = 1'b0;
    localparam logic STATUS_FAIL = 1'b1;
    localparam int STATUS_FAIL_BIT = 0;
    localparam int STATUS_BUSY_BIT = 1;
    localparam int SELECT_FIRST_LSB = 0;
    localparam int SELECT_SECOND_LSB = 2;
    localparam int SELECT_THIRD_LSB = 4;
    localparam int SELECT_CENTER_BIT = 8;

    // ------------------------------------------------------------------
    // Start-up values and code ranges
    // ------------------------------------------------------------------
    localparam logic [1:0] SEL_FIRST_RST = 2'h3;
    localparam logic [1:0] SEL_SECOND_RST = 2'h1;
    localparam logic [1:0] SEL_THIRD_RST = 2'h3;
    localparam logic CENTER_INDEX = 1'b0;
    localparam logic CENTER_ORIGIN = 1'b1;
    localparam logic [15:0] SEL_CODE_MAX = 16'h0003;
    localparam logic [15:0] MON_NUM_MAX = 16'h0002;
    localparam logic [15:0] COORD_MAX = 16'h0001;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

endpackage : msc_pkg

// ==== verilog/msc_mem_if.sv ====
/*
 * Port group between the command handler and its parameter store.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps

interface msc_mem_if #(
    parameter int AW = 6,
    parameter int DW = 32
);
    logic wr_en;
    logic rd_en;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;

    // Handler side drives requests; store side returns registered data.
    modport ctrl (output wr_en, output rd_en, output addr, output wdata, input rdata);
    modport store (input wr_en, input rd_en, input addr, input wdata, output rdata);
endinterface : msc_mem_if

// ==== verilog/msc_param_mem.sv ====
/*
 * Parameter store: a small single-port memory whose read data come from a
 * register one clock after the read request.
 * Assumes one request at a time from the command handler.
 */
`timescale 1ns/100ps

module msc_param_mem #(
    parameter int AW = 6,
    parameter int DW = 32
) (
    input wire logic pclk,
    input wire logic presetn,
    msc_mem_if.store mem
);

    logic [DW-1:0] cells [2**AW];
    logic [DW-1:0] rdata_q;

    // ------------------------------------------------------------------
    // Storage array
    // ------------------------------------------------------------------
    // Cells hold no reset; software loads them before checking them.
    always_ff @(posedge pclk) begin
        if (mem.wr_en) begin
            cells[mem.addr] <= mem.wdata;
        end
    end

    // Read data register, cleared at reset so the output is defined.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= '0;
        end else if (mem.rd_en) begin
            rdata_q <= cells[mem.addr];
        end
    end

    assign mem.rdata = rdata_q;

endmodule : msc_param_mem

// ==== verilog/msc_top.sv ====
/*
 * Monitor select command handler with an APB register slave. Software writes
 * a command word; the block executes parameter check, centre selection,
 * monitor source selection and selection check, and leaves a reply word and
 * a success or failure status. Monitor outputs of both axes follow the
 * selected source codes.
 * Assumes all source and position inputs come from logic on pclk.
 */
// Local design decisions: the register addresses and the APB register port.
// Functional notes
// - Parameter check returns the stored value for the given parameter number.
// - Every setting command returns status zero on success, one on failure.
// - Coordinate command data zero centres on index position; default at start.
// - Coordinate command data one captures present position as the new centre.
// - First monitor selection routes one of four sources to both axes.
// - First monitor starts on deviation source, code three.
// - Second monitor selection routes one of four sources to both axes.
// - Second monitor starts on velocity source, code one.
// - Third monitor selection routes one of four sources to both axes.
// - Third monitor starts on target position source, code three.
// - Selection check returns the current code of monitor zero, one or two.
`timescale 1ns/100ps

module msc_top #(
    parameter int W = 16,
    parameter int PAW = 6
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [W-1:0] scanner_position,
    input wire logic [W-1:0] index_position,
    output logic [W-1:0] raster_center,
    input wire logic [3:0][W-1:0] src_first_axis1,
    input wire logic [3:0][W-1:0] src_first_axis2,
    input wire logic [3:0][W-1:0] src_second_axis1,
    input wire logic [3:0][W-1:0] src_second_axis2,
    input wire logic [3:0][W-1:0] src_third_axis1,
    input wire logic [3:0][W-1:0] src_third_axis2,
    output logic [W-1:0] monitor_first_axis1,
    output logic [W-1:0] monitor_first_axis2,
    output logic [W-1:0] monitor_second_axis1,
    output logic [W-1:0] monitor_second_axis2,
    output logic [W-1:0] monitor_third_axis1,
    output logic [W-1:0] monitor_third_axis2
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0][1:0] sel;
        logic center_sel;
        logic [W-1:0] origin;
        logic [W-1:0] center;
        logic [2:0][1:0][W-1:0] mon;
        logic [31:0] reply;
        logic fail;
        logic busy;
        logic [PAW-1:0] param_index;
        logic [31:0] last_cmd;
        logic [31:0] rdata;
    } msc_state_t;

    msc_state_t state;
    msc_state_t next_state;

    msc_mem_if #(.AW(PAW), .DW(32)) mem_bus ();

    logic setup;
    logic access;
    logic wr_access;
    logic mapped;
    logic cmd_write;
    logic [7:0] cmd_id;
    logic [15:0] cmd_data;
    logic [2:0][1:0][3:0][W-1:0] src;
    logic [2:0][1:0][W-1:0] picked;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    // Every access completes in its first access cycle.
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign wr_access = access && pwrite;
    assign mapped = (paddr == msc_pkg::OFF_COMMAND) || (paddr == msc_pkg::OFF_REPLY) ||
                    (paddr == msc_pkg::OFF_STATUS) || (paddr == msc_pkg::OFF_PARAM_INDEX) ||
                    (paddr == msc_pkg::OFF_PARAM_VALUE) || (paddr == msc_pkg::OFF_SELECT);
    assign pready = access;
    assign pslverr = access && !mapped;
    assign prdata = state.rdata;

    // A command written while the previous one is still running is dropped.
    assign cmd_write = wr_access && (paddr == msc_pkg::OFF_COMMAND) && !state.busy;
    assign cmd_id = pwdata[msc_pkg::CMD_ID_LSB +: msc_pkg::CMD_ID_W];
    assign cmd_data = pwdata[msc_pkg::CMD_DATA_LSB +: msc_pkg::CMD_DATA_W];

    // ------------------------------------------------------------------
    // Parameter store
    // ------------------------------------------------------------------
    // Software loads a value at the indexed slot; a check command reads it.
    assign mem_bus.wr_en = wr_access && (paddr == msc_pkg::OFF_PARAM_VALUE);
    assign mem_bus.wdata = pwdata;
    assign mem_bus.rd_en = cmd_write && (cmd_id == msc_pkg::CMD_PARAM_CHECK) &&
                           (cmd_data < 16'(2**PAW));
    assign mem_bus.addr = mem_bus.rd_en ? cmd_data[PAW-1:0] : state.param_index;

    msc_param_mem #(.AW(PAW), .DW(32)) u_param_mem (
        .pclk(pclk),
        .presetn(presetn),
        .mem(mem_bus.store)
    );

    // ------------------------------------------------------------------
    // Monitor source routing
    // ------------------------------------------------------------------
    assign src[0][0] = src_first_axis1;
    assign src[0][1] = src_first_axis2;
    assign src[1][0] = src_second_axis1;
    assign src[1][1] = src_second_axis2;
    assign src[2][0] = src_third_axis1;
    assign src[2][1] = src_third_axis2;

    // One selector per monitor and axis; both axes share the monitor's code.
    for (genvar g = 0; g < 6; g++) begin : g_route
        // route first, route second, route third
        assign picked[g/2][g%2] = src[g/2][g%2][state.sel[g/2]];
    end

    assign monitor_first_axis1 = state.mon[0][0];
    assign monitor_first_axis2 = state.mon[0][1];
    assign monitor_second_axis1 = state.mon[1][0];
    assign monitor_second_axis2 = state.mon[1][1];
    assign monitor_third_axis1 = state.mon[2][0];
    assign monitor_third_axis2 = state.mon[2][1];
    assign raster_center = state.center;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_state.mon = picked;

        next_state.center = (state.center_sel == msc_pkg::CENTER_ORIGIN) ?
                            state.origin : index_position;

        // Parameter data arrive one cycle after the check was taken.
        if (state.busy) begin
            next_state.reply = mem_bus.rdata;
            next_state.fail = msc_pkg::STATUS_OK;
            next_state.busy = 1'b0;
        end

        if (wr_access && (paddr == msc_pkg::OFF_PARAM_INDEX)) begin
            next_state.param_index = pwdata[PAW-1:0];
        end

        if (cmd_write) begin
            next_state.last_cmd = pwdata;
            next_state.reply = msc_pkg::WORD_ZERO;
            next_state.fail = msc_pkg::STATUS_FAIL;
            case (cmd_id)
                msc_pkg::CMD_PARAM_CHECK: begin
                    if (mem_bus.rd_en) begin
                        next_state.busy = 1'b1;
                    end
                end
                msc_pkg::CMD_COORD_SYSTEM: begin
                    if (cmd_data <= msc_pkg::COORD_MAX) begin
                        next_state.center_sel = cmd_data[0];
                        next_state.fail = msc_pkg::STATUS_OK;
                        if (cmd_data[0] == msc_pkg::CENTER_ORIGIN) begin
                            next_state.origin = scanner_position;
                        end
                    end
                end
                msc_pkg::CMD_SEL_FIRST, msc_pkg::CMD_SEL_SECOND,
                msc_pkg::CMD_SEL_THIRD: begin
                    if (cmd_data <= msc_pkg::SEL_CODE_MAX) begin
                        // store first, store second, store third
                        next_state.sel[2'(cmd_id - msc_pkg::CMD_SEL_FIRST)] = cmd_data[1:0];
                        next_state.fail = msc_pkg::STATUS_OK;
                    end
                end
                msc_pkg::CMD_SEL_CHECK: begin
                    if (cmd_data <= msc_pkg::MON_NUM_MAX) begin
                        next_state.reply = {30'h0000_0000, state.sel[cmd_data[1:0]]};
                        next_state.fail = msc_pkg::STATUS_OK;
                    end
                end
                default: begin
                    next_state.fail = msc_pkg::STATUS_FAIL;
                end
            endcase
        end

        // Read data are captured in the setup cycle and held through access.
        if (setup && !pwrite) begin
            case (paddr)
                msc_pkg::OFF_COMMAND: next_state.rdata = state.last_cmd;
                msc_pkg::OFF_REPLY: next_state.rdata = state.reply;
                msc_pkg::OFF_STATUS: begin
                    next_state.rdata = msc_pkg::WORD_ZERO;
                    next_state.rdata[msc_pkg::STATUS_FAIL_BIT] = state.fail;
                    next_state.rdata[msc_pkg::STATUS_BUSY_BIT] = state.busy;
                end
                msc_pkg::OFF_PARAM_INDEX: begin
                    next_state.rdata = msc_pkg::WORD_ZERO;
                    next_state.rdata[PAW-1:0] = state.param_index;
                end
                msc_pkg::OFF_SELECT: begin
                    next_state.rdata = msc_pkg::WORD_ZERO;
                    next_state.rdata[msc_pkg::SELECT_FIRST_LSB +: 2] = state.sel[0];
                    next_state.rdata[msc_pkg::SELECT_SECOND_LSB +: 2] = state.sel[1];
                    next_state.rdata[msc_pkg::SELECT_THIRD_LSB +: 2] = state.sel[2];
                    next_state.rdata[msc_pkg::SELECT_CENTER_BIT] = state.center_sel;
                end
                default: next_state.rdata = msc_pkg::WORD_ZERO;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0;
            state.sel[0] <= msc_pkg::SEL_FIRST_RST;
            state.sel[1] <= msc_pkg::SEL_SECOND_RST;
            state.sel[2] <= msc_pkg::SEL_THIRD_RST;
            state.center_sel <= msc_pkg::CENTER_INDEX;
            state.fail <= msc_pkg::STATUS_OK;
        end else begin
            state <= next_state;
        end
    end

endmodule : msc_top

// ==== verification/msc_top_asserts.sv ====
/*
 * Checker for the monitor select command block: bus timing, monitor routing
 * and raster centre, seen only at the top module ports.
 * Assumes it is bound into msc_top and that no command arrives while busy.
 */
`timescale 1ns/100ps

module msc_top_asserts #(
    parameter int W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [W-1:0] scanner_position,
    input wire logic [W-1:0] index_position,
    input wire logic [W-1:0] raster_center,
    input wire logic [3:0][W-1:0] src_first_axis1,
    input wire logic [3:0][W-1:0] src_first_axis2,
    input wire logic [3:0][W-1:0] src_second_axis1,
    input wire logic [3:0][W-1:0] src_second_axis2,
    input wire logic [3:0][W-1:0] src_third_axis1,
    input wire logic [3:0][W-1:0] src_third_axis2,
    input wire logic [W-1:0] monitor_first_axis1,
    input wire logic [W-1:0] monitor_first_axis2,
    input wire logic [W-1:0] monitor_second_axis1,
    input wire logic [W-1:0] monitor_second_axis2,
    input wire logic [W-1:0] monitor_third_axis1,
    input wire logic [W-1:0] monitor_third_axis2
);
    // ------------------------------------------------------------------
    // Shadow of the selections, updated at each accepted command edge
    // ------------------------------------------------------------------
    logic [1:0] s1, s2, s3;
    logic cen;
    logic [W-1:0] org;
    logic cmd;
    logic [15:0] cdat;

    // Decode of a command write in its access cycle.
    assign cmd = psel && penable && pwrite && paddr == msc_pkg::OFF_COMMAND;
    assign cdat = pwdata[31:16];

    // Shadow registers; out of range data leave them unchanged.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1 <= msc_pkg::SEL_FIRST_RST;
            s2 <= msc_pkg::SEL_SECOND_RST;
            s3 <= msc_pkg::SEL_THIRD_RST;
            cen <= msc_pkg::CENTER_INDEX;
            org <= '0;
        end else if (cmd && cdat <= msc_pkg::SEL_CODE_MAX) begin
            if (pwdata[7:0] == msc_pkg::CMD_SEL_FIRST) s1 <= cdat[1:0];
            if (pwdata[7:0] == msc_pkg::CMD_SEL_SECOND) s2 <= cdat[1:0];
            if (pwdata[7:0] == msc_pkg::CMD_SEL_THIRD) s3 <= cdat[1:0];
            if (pwdata[7:0] == msc_pkg::CMD_COORD_SYSTEM && cdat <= msc_pkg::COORD_MAX) begin
                cen <= cdat[0];
                if (cdat[0]) org <= scanner_position;
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence apb_acc;
        psel && !penable ##1 psel && penable;
    endsequence

    AST_PREADY_NOWAIT: assert property (apb_acc |-> pready)
        else $error("pready low in the access cycle");
    AST_SLVERR_MAP: assert property (psel && penable |->
        pslverr == !(paddr <= 8'h14 && paddr[1:0] == 2'b00))
        else $error("pslverr does not match the address map");
    AST_MON_FIRST: assert property ($past(presetn) |->
        monitor_first_axis1 == $past(src_first_axis1[s1])
        && monitor_first_axis2 == $past(src_first_axis2[s1]))
        else $error("first monitor carries the wrong source");
    AST_MON_SECOND: assert property ($past(presetn) |->
        monitor_second_axis1 == $past(src_second_axis1[s2])
        && monitor_second_axis2 == $past(src_second_axis2[s2]))
        else $error("second monitor carries the wrong source");
    AST_MON_THIRD: assert property ($past(presetn) |->
        monitor_third_axis1 == $past(src_third_axis1[s3])
        && monitor_third_axis2 == $past(src_third_axis2[s3]))
        else $error("third monitor carries the wrong source");
    AST_CENTER_INDEX: assert property ($past(presetn) && !$past(cen) |->
        raster_center == $past(index_position))
        else $error("centre does not follow the index position");
    AST_CENTER_ORIGIN: assert property ($past(presetn) && $past(cen) |->
        raster_center == $past(org))
        else $error("centre does not hold the captured origin");
    AST_SELECT_READ: assert property (
        psel && penable && !pwrite && paddr == msc_pkg::OFF_SELECT |->
        prdata[8:0] == {cen, 2'b00, s3, s2, s1})
        else $error("select register read differs from the selections");
endmodule : msc_top_asserts

bind msc_top msc_top_asserts #(.W(W)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scanner_position(scanner_position),
    .index_position(index_position), .raster_center(raster_center),
    .src_first_axis1(src_first_axis1), .src_first_axis2(src_first_axis2),
    .src_second_axis1(src_second_axis1), .src_second_axis2(src_second_axis2),
    .src_third_axis1(src_third_axis1), .src_third_axis2(src_third_axis2),
    .monitor_first_axis1(monitor_first_axis1), .monitor_first_axis2(monitor_first_axis2),
    .monitor_second_axis1(monitor_second_axis1),
    .monitor_second_axis2(monitor_second_axis2),
    .monitor_third_axis1(monitor_third_axis1), .monitor_third_axis2(monitor_third_axis2));

// ==== verification/msc_host_model.sv ====
/*
 * Host model: an APB master that issues one register transfer at a time.
 * Assumes a single clock; it waits for pready under a bounded count.
 */
`timescale 1ns/100ps

module msc_host_model (
    input wire logic pclk,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata
);
    // Bus idles deselected from time zero.
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end

    // One transfer: setup, access until pready, then release with scrambled lines.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic err, output logic to);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        err = pslverr;
        to = (n >= 50);
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
endmodule : msc_host_model

// ==== verification/tb_msc_top.sv ====
/*
 * Self-checking bench for the monitor select command block.
 * Assumes the host model drives the bus and the bench drives the sources.
 */
`timescale 1ns/100ps

module tb_msc_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] scanner_position, index_position, raster_center;
    logic [3:0][15:0] src [6];
    logic [15:0] mon [6];
    logic [1:0] sel [3];
    int error_cnt, n_compared;

    msc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scanner_position(scanner_position),
        .index_position(index_position), .raster_center(raster_center),
        .src_first_axis1(src[0]), .src_first_axis2(src[1]), .src_second_axis1(src[2]),
        .src_second_axis2(src[3]), .src_third_axis1(src[4]), .src_third_axis2(src[5]),
        .monitor_first_axis1(mon[0]), .monitor_first_axis2(mon[1]),
        .monitor_second_axis1(mon[2]), .monitor_second_axis2(mon[3]),
        .monitor_third_axis1(mon[4]), .monitor_third_axis2(mon[5]));
    msc_host_model host (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    // Clock at 25 MHz.
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        logic to;
        host.xfer(w, a, d, q, last_err, to);
        if (to) begin
            error_cnt++;
            test_done();
        end
    endtask : bus

    // Command write, bounded poll until not busy, then reply read.
    task automatic cmd(input logic [7:0] id, input logic [15:0] dat, output logic fl,
                       output logic [31:0] rep);
        logic [31:0] s;
        int n;
        bus(1'b1, msc_pkg::OFF_COMMAND, {dat, 8'h00, id}, s);
        n = 0;
        do begin
            bus(1'b0, msc_pkg::OFF_STATUS, 32'h0000_0000, s);
            n++;
        end while (s[msc_pkg::STATUS_BUSY_BIT] !== 1'b0 && n < 8);
        chk(s[msc_pkg::STATUS_BUSY_BIT], 32'h0000_0000);
        if (s[msc_pkg::STATUS_BUSY_BIT] !== 1'b0) test_done();
        fl = s[msc_pkg::STATUS_FAIL_BIT];
        bus(1'b0, msc_pkg::OFF_REPLY, 32'h0000_0000, rep);
    endtask : cmd

    task automatic t_defaults();
        logic [31:0] q;
        bus(1'b0, msc_pkg::OFF_SELECT, 32'h0000_0000, q);
        chk(q, 32'h0000_0037);
        for (int i = 0; i < 6; i++) chk(mon[i], src[i][sel[i/2]]);
    endtask : t_defaults

    task automatic t_select();
        logic fl;
        logic [31:0] r;
        for (int m = 0; m < 3; m++) begin
            for (int c = 4; c >= 0; c--) begin
                cmd(8'(msc_pkg::CMD_SEL_FIRST + m), 16'(c), fl, r);
                chk(fl, 32'(c > 3));
                if (c <= 3) sel[m] = 2'(c);
                chk(mon[2*m], src[2*m][sel[m]]);
                chk(mon[2*m+1], src[2*m+1][sel[m]]);
                cmd(msc_pkg::CMD_SEL_CHECK, 16'(m), fl, r);
                chk(fl, 32'h0000_0000);
                chk(r, {30'h0, sel[m]});
            end
        end
        cmd(msc_pkg::CMD_SEL_CHECK, 16'h0003, fl, r);
        chk(fl, 32'h0000_0001);
        bus(1'b0, msc_pkg::OFF_COMMAND, 32'h0000_0000, r);
        chk(r, {16'h0003, 8'h00, msc_pkg::CMD_SEL_CHECK});
        cmd(8'h00, 16'h0000, fl, r);
        chk(fl, 32'h0000_0001);
        chk(r, 32'h0000_0000);
        bus(1'b0, 8'h40, 32'h0000_0000, r);
        chk(last_err, 32'h0000_0001);
        chk(r, 32'h0000_0000);
    endtask : t_select

    task automatic t_param();
        logic fl;
        logic [31:0] r;
        logic [5:0] ids [3] = '{6'h00, 6'h1A, 6'h3F};
        foreach (ids[i]) begin
            bus(1'b1, msc_pkg::OFF_PARAM_INDEX, {26'h0, ids[i]}, r);
            bus(1'b1, msc_pkg::OFF_PARAM_VALUE, {26'h296_9694, ids[i]}, r);
        end
        foreach (ids[i]) begin
            cmd(msc_pkg::CMD_PARAM_CHECK, {10'h0, ids[i]}, fl, r);
            chk(fl, 32'h0000_0000);
            chk(r, {26'h296_9694, ids[i]});
        end
        cmd(msc_pkg::CMD_PARAM_CHECK, 16'h0040, fl, r);
        chk(fl, 32'h0000_0001);
        bus(1'b0, msc_pkg::OFF_PARAM_INDEX, 32'h0000_0000, r);
        chk(r, 32'h0000_003F);
    endtask : t_param

    task automatic t_center();
        logic fl;
        logic [31:0] r;
        @(posedge pclk);
        index_position <= 16'h0123;
        repeat (3) @(posedge pclk);
        chk(raster_center, 16'h0123);
        scanner_position <= 16'h0BEE;
        cmd(msc_pkg::CMD_COORD_SYSTEM, 16'h0001, fl, r);
        scanner_position <= 16'h0777;
        index_position <= 16'h0456;
        repeat (3) @(posedge pclk);
        chk({fl, raster_center}, {1'b0, 16'h0BEE});
        cmd(msc_pkg::CMD_COORD_SYSTEM, 16'h0002, fl, r);
        chk({fl, raster_center}, {1'b1, 16'h0BEE});
        cmd(msc_pkg::CMD_COORD_SYSTEM, 16'h0000, fl, r);
        chk({fl, raster_center}, {1'b0, 16'h0456});
    endtask : t_center

    // Reset for 16 cycles, then the scenarios in turn.
    initial begin
        error_cnt = 0;
        n_compared = 0;
        presetn = 1'b0;
        scanner_position = 16'h0000;
        index_position = 16'h0000;
        sel = '{2'h3, 2'h1, 2'h3};
        for (int i = 0; i < 6; i++)
            for (int k = 0; k < 4; k++) src[i][k] = 16'(16'h5000 + i * 16 + k);
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_defaults();
        t_select();
        t_param();
        t_center();
        test_done();
    end
endmodule : tb_msc_top
